// ===== core/sosc_pkg.sv
// constants for the safety output and start-up control block
// assumes one 40 MHz clock and a plain strobe register port
package sosc_pkg;

    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned MS_PER_S    = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
    localparam int unsigned RST_MIN_MS  = 120;
    localparam int unsigned RST_MAX_MS  = 4000;
    localparam int unsigned MS_CNT_W    = 13;

    localparam int unsigned NUM_BANKS   = 4;
    localparam int unsigned BANK_W      = 2;
    localparam int unsigned PAIR_W      = 4;
    localparam int unsigned ADDR_W      = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_OUTMAP  = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_MASK    = 8'h0C;
    localparam logic [7:0] ADDR_STATE   = 8'h10;
    localparam logic [7:0] ADDR_BANK0   = 8'h20;

    // control fields
    localparam int unsigned CTRL_FOUR_BIT  = 0;
    localparam int unsigned CTRL_BANK_LSB  = 1;

    // output map fields, two bits each
    localparam int unsigned MAP_NSO_LSB  = 0;
    localparam int unsigned MAP_A1_LSB   = 2;
    localparam int unsigned MAP_GIO_LSB  = 4;
    localparam logic [5:0]  OUTMAP_RST   = 6'h39;

    // bank fields
    localparam int unsigned BK_RESOL_LSB   = 0;
    localparam int unsigned BK_MODE_LSB    = 3;
    localparam int unsigned BK_RESP_LSB    = 8;
    localparam int unsigned BK_SPEED_LSB   = 16;
    localparam logic [2:0]  RESOL_CODE_MAX = 3'h5;
    localparam logic [2:0]  RESOL_RST      = 3'h0;
    localparam logic [7:0]  RESP_MS_RST  = 8'h3C;
    localparam logic [7:0]  SPEED_RST    = 8'h00;

    // status bits
    localparam int unsigned NUM_EV      = 4;
    localparam int unsigned EV_TRIP     = 0;
    localparam int unsigned EV_RST_OK   = 1;
    localparam int unsigned EV_RST_BAD  = 2;
    localparam int unsigned EV_B_VIOL   = 3;

    // logic signal sources for the general outputs
    localparam logic [1:0] SRC_NONE    = 2'h0;
    localparam logic [1:0] SRC_B_CLEAR = 2'h1;
    localparam logic [1:0] SRC_A_WF    = 2'h2;
    localparam logic [1:0] SRC_B_WF    = 2'h3;

    typedef enum logic [1:0] {
        MODE_AUTO      = 2'h0,
        MODE_START_LCK = 2'h1,
        MODE_FULL_LCK  = 2'h2
    } sosc_mode_type;

    typedef enum logic [1:0] {
        ST_START,
        ST_RUN,
        ST_LOCK
    } sosc_state_type;

endpackage

// ===== core/sosc_tick_div.sv
// divider giving a one-cycle enable pulse every DIV clocks
// assumes synchronous active-low reset
`timescale 1ns/1ps
module sosc_tick_div #(
    parameter int unsigned DIV = 40000
) (
    input  wire logic clk,    // device clock
    input  wire logic rst_n,  // sync reset, active low
    output logic      tick    // one-cycle enable
);
    localparam int unsigned CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule // sosc_tick_div

// ===== core/sosc_reset_qual.sv
// reset button press-width qualifier, judged at release
// assumes button input synchronous and a millisecond tick
`timescale 1ns/1ps
module sosc_reset_qual
    import sosc_pkg::*;
#(
    parameter int unsigned MIN_MS = RST_MIN_MS,
    parameter int unsigned MAX_MS = RST_MAX_MS
) (
    input  wire logic clk,      // device clock
    input  wire logic rst_n,    // sync reset, active low
    input  wire logic tick_ms,  // millisecond enable
    input  wire logic button,   // reset button, high while pressed
    output logic      valid,    // pulse: release after valid hold
    output logic      invalid   // pulse: release after bad hold
);
    logic [MS_CNT_W-1:0] held_q;
    logic                btn_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            btn_q <= 1'b0;
        end else begin
            btn_q <= button;
        end
    end

    // saturating hold counter
    always_ff @(posedge clk) begin
        if (!rst_n || !button) begin
            held_q <= '0;
        end else if (tick_ms && held_q <= MS_CNT_W'(MAX_MS)) begin
            held_q <= held_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid   <= 1'b0;
            invalid <= 1'b0;
        end else begin
            valid   <= btn_q && !button && held_q >= MS_CNT_W'(MIN_MS)
                       && held_q <= MS_CNT_W'(MAX_MS);
            invalid <= btn_q && !button && (held_q < MS_CNT_W'(MIN_MS)
                       || held_q > MS_CNT_W'(MAX_MS));
        end
    end
endmodule // sosc_reset_qual

// ===== core/sosc_top.sv
// safety output and start-up control with register port
// assumes field flags and reset button synchronous to clk
//
// Overview of operation
// - first function violation switches safety outputs off
// - second function violation raises non-safe clear only
// - four field mode gives per-function warning indications
// - output signal mapping set by register
// - resolution per bank, six allowed values
// - maximum vehicle speed held per bank
// - outputs off within response time of violation
// - start-up behaviour selected per bank
// - automatic mode: no reset needed ever
// - start interlock: off after power until reset
// - start interlock: auto restart when field clears
// - restart interlock: stays off until valid reset
// - restart interlock also blocks power-up start
// - four field mode selects matching pairs together
`timescale 1ns/1ps
module sosc_top
    import sosc_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic              clk,           // 40 MHz clock
    input  wire logic              rst_n,         // sync reset, active low
    input  wire logic              pf_a_viol,     // first protective field violated
    input  wire logic              pf_b_viol,     // second protective field violated
    input  wire logic              wf_a_viol,     // first warning field violated
    input  wire logic              wf_b_viol,     // second warning field violated
    input  wire logic              reset_button,  // operator reset, high pressed
    input  wire logic [PAIR_W-1:0] pair_sel,      // field pair chosen by control
    input  wire logic [ADDR_W-1:0] reg_addr,      // register byte address
    input  wire logic [31:0]       reg_wdata,     // register write data
    input  wire logic              reg_wr,        // write strobe
    input  wire logic              reg_rd,        // read strobe
    output logic [31:0]            reg_rdata,     // read data, cycle after strobe
    output logic                   safety_outputs_first_function, // safety output
    output logic                   non_safe_signal_output,        // mapped output
    output logic                   aux_output_a1,                 // mapped output
    output logic                   general_io_output_one,         // mapped output
    output logic                   first_warning_violation_ind,   // warning ind A
    output logic                   second_warning_violation_ind,  // warning ind B
    output logic [PAIR_W-1:0]      pair_first_q,  // pair monitored, first function
    output logic [PAIR_W-1:0]      pair_second_q, // pair monitored, second function
    output logic                   irq            // interrupt, level
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic pick_src(input logic [1:0] src, input logic b_clr,
                                      input logic a_wf, input logic b_wf);
        case (src)
            SRC_B_CLEAR: pick_src = b_clr;
            SRC_A_WF:    pick_src = a_wf;
            SRC_B_WF:    pick_src = b_wf;
            default:     pick_src = 1'b0;
        endcase
    endfunction

    function automatic logic is_addr(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] ref_a);
        is_addr = (a == ADDR_W'(ref_a));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic                 four_field_q;
    logic [BANK_W-1:0]    bank_act_q;
    logic [5:0]           outmap_q;
    logic [NUM_EV-1:0]    status_q;
    logic [NUM_EV-1:0]    mask_q;
    logic [2:0]           resol_q [NUM_BANKS];
    sosc_mode_type        mode_q  [NUM_BANKS];
    logic [7:0]           resp_q  [NUM_BANKS];
    logic [7:0]           speed_q [NUM_BANKS];
    sosc_state_type       state_q;
    sosc_state_type       state_d;
    logic                 tick_ms;
    logic                 rst_valid;
    logic                 rst_invalid;
    logic                 pf_a_q;
    logic                 pf_b_q;
    logic [NUM_EV-1:0]    ev_set;
    logic                 bank_hit;
    logic [BANK_W-1:0]    bank_idx;
    sosc_mode_type        mode_act;
    logic                 b_clear;
    logic                 a_wf_ind;
    logic                 b_wf_ind;

    assign bank_idx = reg_addr[BANK_W+1:2];
    assign bank_hit = reg_addr[ADDR_W-1:BANK_W+2] == ADDR_BANK0[ADDR_W-1:BANK_W+2];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            four_field_q <= 1'b0;
            bank_act_q   <= '0;
            outmap_q     <= OUTMAP_RST;
            mask_q       <= '0;
        end else if (reg_wr) begin
            if (is_addr(reg_addr, ADDR_CTRL)) begin
                four_field_q <= reg_wdata[CTRL_FOUR_BIT];
                bank_act_q   <= reg_wdata[CTRL_BANK_LSB +: BANK_W];
            end
            if (is_addr(reg_addr, ADDR_OUTMAP)) begin
                outmap_q <= reg_wdata[5:0];
            end
            if (is_addr(reg_addr, ADDR_MASK)) begin
                mask_q <= reg_wdata[NUM_EV-1:0];
            end
        end
    end

    // per-bank settings; bad resolution or mode codes leave the bank as it was
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                resol_q[b] <= RESOL_RST;
                mode_q[b]  <= MODE_FULL_LCK;
                resp_q[b]  <= RESP_MS_RST;
                speed_q[b] <= SPEED_RST;
            end
        end else if (reg_wr && bank_hit
                     && reg_wdata[BK_RESOL_LSB +: 3] <= RESOL_CODE_MAX
                     && reg_wdata[BK_MODE_LSB +: 2] <= MODE_FULL_LCK) begin
            resol_q[bank_idx] <= reg_wdata[BK_RESOL_LSB +: 3];
            mode_q[bank_idx]  <= sosc_mode_type'(reg_wdata[BK_MODE_LSB +: 2]);
            resp_q[bank_idx]  <= reg_wdata[BK_RESP_LSB +: 8];
            speed_q[bank_idx] <= reg_wdata[BK_SPEED_LSB +: 8];
        end
    end

    // status: set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= '0;
        end else if (reg_wr && is_addr(reg_addr, ADDR_STATUS)) begin
            status_q <= (status_q & ~reg_wdata[NUM_EV-1:0]) | ev_set;
        end else begin
            status_q <= status_q | ev_set;
        end
    end

    assign irq = |(status_q & mask_q);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (is_addr(reg_addr, ADDR_CTRL)) begin
            reg_rdata <= {29'h0, bank_act_q, four_field_q};
        end else if (is_addr(reg_addr, ADDR_OUTMAP)) begin
            reg_rdata <= {26'h0, outmap_q};
        end else if (is_addr(reg_addr, ADDR_STATUS)) begin
            reg_rdata <= {28'h0, status_q};
        end else if (is_addr(reg_addr, ADDR_MASK)) begin
            reg_rdata <= {28'h0, mask_q};
        end else if (is_addr(reg_addr, ADDR_STATE)) begin
            reg_rdata <= {24'h0, pair_first_q, 1'b0,
                          safety_outputs_first_function, state_q};
        end else if (bank_hit) begin
            reg_rdata <= {8'h0, speed_q[bank_idx], resp_q[bank_idx],
                          3'h0, mode_q[bank_idx], resol_q[bank_idx]};
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset button qualification

    sosc_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick_ms)
    );

    sosc_reset_qual u_rq (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick_ms (tick_ms),
        .button  (reset_button),
        .valid   (rst_valid),
        .invalid (rst_invalid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // start-up state machine

    assign mode_act = mode_q[bank_act_q];

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_START: begin
                if (mode_act == MODE_AUTO) begin
                    state_d = ST_RUN;
                end else if (rst_valid && !pf_a_viol) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pf_a_viol && mode_act == MODE_FULL_LCK) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (mode_act == MODE_AUTO) begin
                    state_d = ST_RUN;
                end else if (rst_valid && !pf_a_viol) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_START;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_START;
        end else begin
            state_q <= state_d;
        end
    end

    // off on the cycle after violation, far inside any response time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            safety_outputs_first_function <= 1'b0;
        end else begin
            safety_outputs_first_function <= (state_d == ST_RUN)
                                             && !pf_a_viol;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indications and mapped outputs

    assign b_clear  = pf_b_viol;
    assign a_wf_ind = four_field_q && wf_a_viol;
    assign b_wf_ind = four_field_q && wf_b_viol;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            non_safe_signal_output       <= 1'b0;
            aux_output_a1                <= 1'b0;
            general_io_output_one        <= 1'b0;
            first_warning_violation_ind  <= 1'b0;
            second_warning_violation_ind <= 1'b0;
        end else begin
            non_safe_signal_output <= pick_src(outmap_q[MAP_NSO_LSB +: 2],
                                               b_clear, a_wf_ind, b_wf_ind);
            aux_output_a1          <= pick_src(outmap_q[MAP_A1_LSB +: 2],
                                               b_clear, a_wf_ind, b_wf_ind);
            general_io_output_one  <= pick_src(outmap_q[MAP_GIO_LSB +: 2],
                                               b_clear, a_wf_ind, b_wf_ind);
            first_warning_violation_ind  <= a_wf_ind;
            second_warning_violation_ind <= b_wf_ind;
        end
    end

    // first function follows the pair number; second follows it only in four field mode, else zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_first_q  <= '0;
            pair_second_q <= '0;
        end else begin
            pair_first_q  <= pair_sel;
            pair_second_q <= four_field_q ? pair_sel : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pf_a_q <= 1'b0;
            pf_b_q <= 1'b0;
        end else begin
            pf_a_q <= pf_a_viol;
            pf_b_q <= pf_b_viol;
        end
    end

    always_comb begin
        ev_set             = '0;
        ev_set[EV_TRIP]    = pf_a_viol && !pf_a_q;
        ev_set[EV_RST_OK]  = rst_valid && !pf_a_viol && state_q != ST_RUN;
        ev_set[EV_RST_BAD] = rst_invalid || (rst_valid && pf_a_viol);
        ev_set[EV_B_VIOL]  = pf_b_viol && !pf_b_q;
    end

endmodule // sosc_top

// ===== bench/sosc_top_sva.sv
// concurrent checks on the ports of the output control block
// assumes one clock and a synchronous active-low reset; bound from the bench
`timescale 1ns/1ps
module sosc_top_sva
    import sosc_pkg::*;
(
    input wire logic              clk,                           // device clock
    input wire logic              rst_n,                         // sync reset
    input wire logic              pf_a_viol,                     // field a violated
    input wire logic              wf_a_viol,                     // warning a
    input wire logic              wf_b_viol,                     // warning b
    input wire logic [PAIR_W-1:0] pair_sel,                      // pair choice
    input wire logic              reg_rd,                        // read strobe
    input wire logic [31:0]       reg_rdata,                     // read data
    input wire logic              safety_outputs_first_function, // safety output
    input wire logic              first_warning_violation_ind,   // warning ind a
    input wire logic              second_warning_violation_ind,  // warning ind b
    input wire logic [PAIR_W-1:0] pair_first_q,                  // pair a
    input wire logic [PAIR_W-1:0] pair_second_q                  // pair b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    a_trip_off: assert property (pf_a_viol |=> !safety_outputs_first_function)
        else $error("safety output still on after field a violation");
    a_trip_held: assert property ($fell(pf_a_viol) |-> !safety_outputs_first_function)
        else $error("safety output on while violation just ended");
    a_b_keeps: assert property (safety_outputs_first_function && !pf_a_viol
        |=> safety_outputs_first_function)
        else $error("safety output dropped without field a violation");
    a_warn_a_quiet: assert property (!wf_a_viol |=> !first_warning_violation_ind)
        else $error("warning a indication without warning a");
    a_warn_b_quiet: assert property (!wf_b_viol |=> !second_warning_violation_ind)
        else $error("warning b indication without warning b");
    a_pair_follow: assert property ($past(rst_n) |-> pair_first_q == $past(pair_sel))
        else $error("first pair does not follow selection");
    a_pair_match: assert property (pair_second_q != '0 |-> pair_second_q == pair_first_q)
        else $error("second pair differs from first pair");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data present without read");
endmodule // sosc_top_sva

// ===== bench/sosc_operator_model.sv
// operator at the reset button: holds it for one clock more than the commanded number of clocks
// assumes the bench commands widths; valid widths keep the hold window
`timescale 1ns/1ps
module sosc_operator_model (
    input wire logic        clk,          // device clock
    input wire logic        press_go,     // start a press
    input wire logic [15:0] press_cycles, // hold length in clocks, less one
    output logic            reset_button  // button, high pressed
);
    logic [15:0] cnt_q = 16'h0000;

    initial reset_button = 1'b0;
    // hold then release; hold width chosen by bench
    always @(posedge clk) begin
        if (press_go) begin
            reset_button <= 1'b1;
            cnt_q        <= press_cycles;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end else begin
            reset_button <= 1'b0;
        end
    end
endmodule // sosc_operator_model

// ===== bench/safety_output_startup_control_tb_top.sv
// self-checking bench for the output and start-up control block
// assumes sosc_top with a shortened millisecond tick of 4 clocks
`timescale 1ns/1ps
module safety_output_startup_control_tb_top;
    import sosc_pkg::*;
    localparam int TDIV = 4;
    logic clk, rst_n, pf_a_viol, pf_b_viol, wf_a_viol, wf_b_viol, reset_button;
    logic reg_wr, reg_rd, press_go, safe, nso, a1, gio1, wia, wib, irq;
    logic [PAIR_W-1:0] pair_sel, pfq, psq;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata;
    logic [15:0]       press_cycles;
    int                n_mismatch = 0;
    int                compares   = 0;

    sosc_top #(.TICK_DIV(TDIV)) dut (.clk(clk), .rst_n(rst_n), .pf_a_viol(pf_a_viol),
        .pf_b_viol(pf_b_viol), .wf_a_viol(wf_a_viol), .wf_b_viol(wf_b_viol),
        .reset_button(reset_button), .pair_sel(pair_sel), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .safety_outputs_first_function(safe), .non_safe_signal_output(nso),
        .aux_output_a1(a1), .general_io_output_one(gio1),
        .first_warning_violation_ind(wia), .second_warning_violation_ind(wib),
        .pair_first_q(pfq), .pair_second_q(psq), .irq(irq));
    sosc_operator_model opm (.clk(clk), .press_go(press_go), .press_cycles(press_cycles),
        .reset_button(reset_button));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check_bit(logic got, logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_word(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check_word(reg_rdata, e);
    endtask
    task automatic press(int ticks);
        int w;
        @(posedge clk);
        press_go <= 1'b1; press_cycles <= 16'(ticks * TDIV);
        @(posedge clk);
        press_go <= 1'b0;
        cyc(2);
        for (w = 0; reset_button && w < 20000; w++) @(posedge clk);
        if (w >= 20000) n_mismatch++;
        cyc(6);
    endtask
    task automatic field_a(logic v);
        @(posedge clk) pf_a_viol <= v;
        cyc(1);
    endtask
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rd(ADDR_OUTMAP, 32'h0000_0039);
        rd(ADDR_MASK, 32'h0000_0000);
        rd(ADDR_BANK0, 32'h0000_3C10);
        rd(8'h44, 32'h0000_0000);
        rd(ADDR_STATE, 32'h0000_0000);
    endtask
    task automatic t_restart_lock();
        cyc(50); check_bit(safe, 1'b0);
        press(200); check_bit(safe, 1'b1);
        field_a(1'b1); check_bit(safe, 1'b0);
        field_a(1'b0); cyc(10); check_bit(safe, 1'b0);
        press(50); check_bit(safe, 1'b0);
        press(4100); check_bit(safe, 1'b0);
        field_a(1'b1); press(200); check_bit(safe, 1'b0);
        field_a(1'b0); cyc(5); check_bit(safe, 1'b0);
        press(200); check_bit(safe, 1'b1);
        rd(ADDR_STATE, 32'h0000_0005);
        rd(ADDR_STATUS, 32'h0000_0007);
        wr(ADDR_STATUS, 32'h0000_0007);
        rd(ADDR_STATUS, 32'h0000_0000);
    endtask
    task automatic t_start_lock();
        do_reset();
        wr(ADDR_BANK0, 32'h0000_3C08);
        cyc(40); check_bit(safe, 1'b0);
        press(200); check_bit(safe, 1'b1);
        field_a(1'b1); check_bit(safe, 1'b0);
        field_a(1'b0); cyc(1); check_bit(safe, 1'b1);
    endtask
    task automatic t_auto();
        do_reset();
        wr(ADDR_BANK0, 32'h0000_3C00);
        cyc(4); check_bit(safe, 1'b1);
        field_a(1'b1); check_bit(safe, 1'b0);
        field_a(1'b0); cyc(1); check_bit(safe, 1'b1);
    endtask
    task automatic t_four_field();
        wr(ADDR_CTRL, 32'h0000_0001);
        @(posedge clk);
        pair_sel <= 4'h5; pf_b_viol <= 1'b1; wf_a_viol <= 1'b1;
        cyc(3);
        check_word({28'h0, pfq}, 32'h5);
        check_word({28'h0, psq}, 32'h5);
        check_bit(nso, 1'b1); check_bit(safe, 1'b1);
        check_bit(wia, 1'b1); check_bit(a1, 1'b1); check_bit(wib, 1'b0);
        @(posedge clk);
        pf_b_viol <= 1'b0; wf_a_viol <= 1'b0; wf_b_viol <= 1'b1;
        cyc(3);
        check_bit(wib, 1'b1); check_bit(gio1, 1'b1); check_bit(a1, 1'b0);
        wr(ADDR_OUTMAP, 32'h0000_0007);
        cyc(3);
        check_bit(nso, 1'b1); check_bit(gio1, 1'b0);
        rd(ADDR_OUTMAP, 32'h0000_0007);
        wr(ADDR_CTRL, 32'h0000_0000);
        cyc(3);
        check_bit(wib, 1'b0); check_word({28'h0, psq}, 32'h0);
        @(posedge clk) wf_b_viol <= 1'b0;
    endtask
    task automatic t_banks_irq();
        logic [31:0] v;
        for (int c = 0; c < 6; c++) begin
            v = 32'h007F_2808 | 32'(c);
            wr(8'h24, v);
            rd(8'h24, v);
        end
        wr(8'h24, 32'h0011_2806);
        rd(8'h24, v);
        wr(8'h24, 32'h0011_2818);
        rd(8'h24, v);
        wr(ADDR_STATUS, 32'h0000_000F);
        wr(ADDR_MASK, 32'h0000_0001);
        field_a(1'b1); field_a(1'b0); cyc(2); check_bit(irq, 1'b1);
        wr(ADDR_STATUS, 32'h0000_0001);
        cyc(1); check_bit(irq, 1'b0);
        wr(ADDR_MASK, 32'h0000_0000);
        field_a(1'b1); field_a(1'b0); cyc(2); check_bit(irq, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0001);
        // bank 2 keeps its restart interlock default
        wr(ADDR_CTRL, 32'h0000_0004);
        field_a(1'b1); field_a(1'b0); cyc(2); check_bit(safe, 1'b0);
        rd(ADDR_STATE, 32'h0000_0052);
        wr(ADDR_CTRL, 32'h0000_0000);
        cyc(2); check_bit(safe, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0; rst_n = 1'b0; pf_a_viol = 1'b0; pf_b_viol = 1'b0;
        wf_a_viol = 1'b0; wf_b_viol = 1'b0; pair_sel = '0; reg_addr = '0;
        reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; press_go = 1'b0;
        press_cycles = 16'h0000;
        do_reset();
        t_defaults();
        t_restart_lock();
        t_start_lock();
        t_auto();
        t_four_field();
        t_banks_irq();
        summarize();
    end
    // watchdog sized well above the longest press sequence
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule // safety_output_startup_control_tb_top

bind sosc_top sosc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .pf_a_viol(pf_a_viol),
    .wf_a_viol(wf_a_viol), .wf_b_viol(wf_b_viol), .pair_sel(pair_sel), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .safety_outputs_first_function(safety_outputs_first_function),
    .first_warning_violation_ind(first_warning_violation_ind),
    .second_warning_violation_ind(second_warning_violation_ind),
    .pair_first_q(pair_first_q), .pair_second_q(pair_second_q));
